// File: rtl/srs_pkg.sv
/*
  Shared constants of the speed reference selector: parameter numbers,
  reset values and value ranges.
  Assumes values are signed 16-bit counts where 1000 means full speed.
*/
package srs_pkg;
  // ----------------------------------------------------------------------
  // parameter numbers (index of each setting on the parameter port)
  // ----------------------------------------------------------------------
  localparam logic [4:0] PN_PRE_OFFSET_MON = 5'h01;
  localparam logic [4:0] PN_POST_OFFSET_MON = 5'h02;
  localparam logic [4:0] PN_PRE_RAMP_MON = 5'h03;
  localparam logic [4:0] PN_REF_OFFSET = 5'h04;
  localparam logic [4:0] PN_JOG_REF = 5'h05;
  localparam logic [4:0] PN_FWD_MAX = 5'h06;
  localparam logic [4:0] PN_FWD_MIN = 5'h07;
  localparam logic [4:0] PN_REV_MIN = 5'h08;
  localparam logic [4:0] PN_REV_MAX = 5'h09;
  localparam logic [4:0] PN_SIGNED_SEL = 5'h0A;
  localparam logic [4:0] PN_REF_GATE_ON = 5'h0B;
  localparam logic [4:0] PN_POL_INVERT = 5'h0C;
  localparam logic [4:0] PN_JOG_SEL = 5'h0D;
  localparam logic [4:0] PN_SRC_SEL_LOW = 5'h0E;
  localparam logic [4:0] PN_SRC_SEL_HIGH = 5'h0F;
  localparam logic [4:0] PN_START_ILK = 5'h10;
  localparam logic [4:0] PN_STORED_REF1 = 5'h11;
  localparam logic [4:0] PN_STORED_REF2 = 5'h12;
  localparam logic [4:0] PN_STORED_REF3 = 5'h13;
  localparam logic [4:0] PN_STORED_REF4 = 5'h14;

  // ----------------------------------------------------------------------
  // value ranges and reset values
  // ----------------------------------------------------------------------
  localparam logic signed [15:0] FULL_POS = 16'sh03E8;
  localparam logic signed [15:0] FULL_NEG = -16'sh03E8;
  localparam logic signed [15:0] ZERO_REF = 16'sh0000;
  localparam logic signed [15:0] RST_OFFSET = 16'sh0000;
  localparam logic signed [15:0] RST_JOG_REF = 16'sh0032;
  localparam logic signed [15:0] RST_FWD_MAX = 16'sh03E8;
  localparam logic signed [15:0] RST_FWD_MIN = 16'sh0000;
  localparam logic signed [15:0] RST_REV_MIN = 16'sh0000;
  localparam logic signed [15:0] RST_REV_MAX_4Q = -16'sh03E8;
  localparam logic signed [15:0] RST_REV_MAX_1Q = 16'sh0000;
  localparam logic signed [15:0] RST_STORED_REF1 = 16'sh0000;
  localparam logic signed [15:0] RST_STORED_REF2 = 16'sh012C;
  localparam logic signed [15:0] RST_STORED_REF3 = 16'sh0000;
  localparam logic signed [15:0] RST_STORED_REF4 = 16'sh0000;
  // start interlock window, exclusive bounds, in 0.1 % of full speed
  localparam logic signed [15:0] ILK_WINDOW_POS = 16'sh0008;
  localparam logic signed [15:0] ILK_WINDOW_NEG = -16'sh0008;
endpackage

// File: rtl/srs_speed_ref.sv
/*
  Speed reference selector: four stored references, inch override, offset,
  bipolar/unipolar handling, reversal, speed limits, reference-on gate and
  zero-reference start interlock.
  Assumes one 50 MHz clock, settings written over the parameter port from
  logic on the same clock, and a ramp stage downstream of pre_ramp_ref_q.
*/
// Overview of operation
// - two selector bits pick stored reference
// - stored references span plus/minus full speed
// - references writable unless routed, path keeps running
// - order: offset, polarity mode, reverse, limits
// - post-offset is source plus signed offset, clamped to plus/minus full speed
// - bipolar keeps sign; unipolar zeroes negatives
// - reverse selector inverts reference polarity
// - inch selector substitutes inch reference
// - forward maximum clamp, 0 to 1000
// - forward minimum setting, 0 to 1000
// - reverse maximum, fixed zero one-quadrant
// - reverse minimum setting, -1000 to 0
// - minimum limits ignored in bipolar mode
// - reference-on low forces pre-ramp zero
// - run-permit loss clears; set refused without
// - programmable input drives gate when sequencing off
// - interlock blocks start outside -7..+7 window
// - external speed input routed into reference one
// - reference two 300; three/four follow inputs
// - three read-only reference monitors
// - pre-ramp output feeds the ramp stage
`timescale 1ns/10ps
module srs_speed_ref
  import srs_pkg::*;
#(
  parameter bit FOUR_QUADRANT = 1'b1
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic par_wr_en,
  input wire logic [4:0] par_wr_num,
  input wire logic [15:0] par_wr_data,
  input wire logic [4:0] par_rd_num,
  output logic [15:0] par_rd_data,
  output logic par_wr_refused,
  input wire logic run_permit_input,
  input wire logic [15:0] external_speed_input_pin,
  input wire logic [15:0] general_analog_input_three,
  input wire logic [15:0] general_analog_input_four,
  input wire logic route_ext_to_ref_one,
  input wire logic route_gp_to_ref_three,
  input wire logic route_gp_to_ref_four,
  input wire logic seq_logic_disable,
  input wire logic prog_ref_gate_on,
  output logic signed [15:0] pre_ramp_ref_q,
  output logic start_permit_q,
  output logic ref_gate_on_q
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic signed [15:0] sat_range(input logic signed [16:0] v,
    input logic signed [15:0] lo, input logic signed [15:0] hi);
    logic signed [15:0] r;
    r = v[15:0];
    if (v > 17'(hi))
      r = hi;
    else if (v < 17'(lo))
      r = lo;
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic permit_m_q, permit_s_q;
  logic [15:0] ext_m_q, ext_s_q, gp3_m_q, gp3_s_q, gp4_m_q, gp4_s_q;

  always_ff @(posedge core_clk)
  begin
    permit_m_q <= run_permit_input;
    permit_s_q <= permit_m_q;
    ext_m_q <= external_speed_input_pin;
    ext_s_q <= ext_m_q;
    gp3_m_q <= general_analog_input_three;
    gp3_s_q <= gp3_m_q;
    gp4_m_q <= general_analog_input_four;
    gp4_s_q <= gp4_m_q;
  end

  // ----------------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------------
  logic signed [15:0] offset_q, jog_ref_q, fwd_max_q, fwd_min_q, rev_min_q, rev_max_q;
  logic signed [15:0] stored_ref_q [4];
  logic signed_sel_q, pol_inv_q, jog_sel_q, src_lo_q, src_hi_q, start_ilk_q;
  logic signed [16:0] wr_ext;
  logic signed [15:0] wr_full;
  logic signed [15:0] rst_rev_max;

  assign wr_ext = {par_wr_data[15], par_wr_data};
  assign wr_full = sat_range(wr_ext, FULL_NEG, FULL_POS);
  assign rst_rev_max = FOUR_QUADRANT ? RST_REV_MAX_4Q : RST_REV_MAX_1Q;

  // writes land whatever the path is doing; nothing stalls for them
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      offset_q <= RST_OFFSET;
      jog_ref_q <= RST_JOG_REF;
      fwd_max_q <= RST_FWD_MAX;
      fwd_min_q <= RST_FWD_MIN;
      rev_min_q <= RST_REV_MIN;
      rev_max_q <= rst_rev_max;
      signed_sel_q <= FOUR_QUADRANT;
      pol_inv_q <= 1'b0;
      jog_sel_q <= 1'b0;
      src_lo_q <= 1'b0;
      src_hi_q <= 1'b0;
      start_ilk_q <= 1'b0;
    end
    else if (par_wr_en)
    begin
      case (par_wr_num)
        PN_REF_OFFSET: offset_q <= wr_full;
        PN_JOG_REF: jog_ref_q <= wr_full;
        PN_FWD_MAX: fwd_max_q <= sat_range(wr_ext, ZERO_REF, FULL_POS);
        PN_FWD_MIN: fwd_min_q <= sat_range(wr_ext, ZERO_REF, FULL_POS);
        PN_REV_MIN: rev_min_q <= sat_range(wr_ext, FULL_NEG, ZERO_REF);
        PN_REV_MAX: rev_max_q <= FOUR_QUADRANT ?
          sat_range(wr_ext, FULL_NEG, ZERO_REF) : ZERO_REF;
        PN_SIGNED_SEL: signed_sel_q <= par_wr_data[0];
        PN_POL_INVERT: pol_inv_q <= par_wr_data[0];
        PN_JOG_SEL: jog_sel_q <= par_wr_data[0];
        PN_SRC_SEL_LOW: src_lo_q <= par_wr_data[0];
        PN_SRC_SEL_HIGH: src_hi_q <= par_wr_data[0];
        PN_START_ILK: start_ilk_q <= par_wr_data[0];
        default: ;
      endcase
    end
  end

  // stored references; a routed analog input overrides writes each cycle
  logic [3:0] route_en;
  logic signed [15:0] route_val [4];
  logic signed [15:0] rst_val [4];

  assign route_en = {route_gp_to_ref_four, route_gp_to_ref_three, 1'b0, route_ext_to_ref_one};
  assign route_val[0] = sat_range({ext_s_q[15], ext_s_q}, FULL_NEG, FULL_POS);
  assign route_val[1] = ZERO_REF;
  assign route_val[2] = sat_range({gp3_s_q[15], gp3_s_q}, FULL_NEG, FULL_POS);
  assign route_val[3] = sat_range({gp4_s_q[15], gp4_s_q}, FULL_NEG, FULL_POS);
  assign rst_val[0] = RST_STORED_REF1;
  assign rst_val[1] = RST_STORED_REF2;
  assign rst_val[2] = RST_STORED_REF3;
  assign rst_val[3] = RST_STORED_REF4;

  for (genvar i = 0; i < 4; i++)
  begin : g_ref
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
        stored_ref_q[i] <= rst_val[i];
      else if (route_en[i])
        stored_ref_q[i] <= route_val[i];
      else if (par_wr_en && par_wr_num == PN_STORED_REF1 + 5'(i))
        stored_ref_q[i] <= wr_full;
    end
  end

  // ----------------------------------------------------------------------
  // reference-on gate
  // ----------------------------------------------------------------------
  logic gate_wr;
  assign gate_wr = par_wr_en && par_wr_num == PN_REF_GATE_ON;
  // a set attempt without run permit is reported, not stored
  assign par_wr_refused = gate_wr && par_wr_data[0] && !permit_s_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ref_gate_on_q <= 1'b0;
    else if (!permit_s_q)
      ref_gate_on_q <= 1'b0;
    else if (seq_logic_disable)
      ref_gate_on_q <= prog_ref_gate_on;
    else if (gate_wr)
      ref_gate_on_q <= par_wr_data[0];
  end

  // ----------------------------------------------------------------------
  // reference path
  // ----------------------------------------------------------------------
  logic signed [15:0] src_ref, post_off, polar, inverted, limited;
  logic signed [15:0] pre_offset_q, post_offset_q;

  always_comb
  begin
    // source, offset, polarity mode, reversal, limits
    src_ref = stored_ref_q[{src_hi_q, src_lo_q}];
    if (jog_sel_q)
      src_ref = jog_ref_q;
    post_off = sat_range(17'(src_ref) + 17'(offset_q), FULL_NEG, FULL_POS);
    polar = (!signed_sel_q && post_off < 0) ? ZERO_REF : post_off;
    inverted = pol_inv_q ? -polar : polar;
    limited = inverted;
    if (inverted > 0)
    begin
      if (!signed_sel_q && inverted < fwd_min_q)
        limited = fwd_min_q;
      if (limited > fwd_max_q)
        limited = fwd_max_q;
    end
    else if (inverted < 0)
    begin
      if (!signed_sel_q && inverted > rev_min_q)
        limited = rev_min_q;
      if (limited < rev_max_q)
        limited = rev_max_q;
    end
  end

  // every stage follows the settings one edge later
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pre_offset_q <= ZERO_REF;
      post_offset_q <= ZERO_REF;
      pre_ramp_ref_q <= ZERO_REF;
    end
    else
    begin
      pre_offset_q <= src_ref;
      post_offset_q <= post_off;
      pre_ramp_ref_q <= ref_gate_on_q ? limited : ZERO_REF;
    end
  end

  // interlock judged on the registered pre-offset monitor
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      start_permit_q <= 1'b1;
    else
      start_permit_q <= !start_ilk_q ||
        (pre_offset_q > ILK_WINDOW_NEG && pre_offset_q < ILK_WINDOW_POS);
  end

  // ----------------------------------------------------------------------
  // parameter read-back
  // ----------------------------------------------------------------------
  always_comb
  begin
    case (par_rd_num)
      PN_PRE_OFFSET_MON: par_rd_data = pre_offset_q;
      PN_POST_OFFSET_MON: par_rd_data = post_offset_q;
      PN_PRE_RAMP_MON: par_rd_data = pre_ramp_ref_q;
      PN_REF_OFFSET: par_rd_data = offset_q;
      PN_JOG_REF: par_rd_data = jog_ref_q;
      PN_FWD_MAX: par_rd_data = fwd_max_q;
      PN_FWD_MIN: par_rd_data = fwd_min_q;
      PN_REV_MIN: par_rd_data = rev_min_q;
      PN_REV_MAX: par_rd_data = rev_max_q;
      PN_SIGNED_SEL: par_rd_data = {15'h0000, signed_sel_q};
      PN_REF_GATE_ON: par_rd_data = {15'h0000, ref_gate_on_q};
      PN_POL_INVERT: par_rd_data = {15'h0000, pol_inv_q};
      PN_JOG_SEL: par_rd_data = {15'h0000, jog_sel_q};
      PN_SRC_SEL_LOW: par_rd_data = {15'h0000, src_lo_q};
      PN_SRC_SEL_HIGH: par_rd_data = {15'h0000, src_hi_q};
      PN_START_ILK: par_rd_data = {15'h0000, start_ilk_q};
      PN_STORED_REF1: par_rd_data = stored_ref_q[0];
      PN_STORED_REF2: par_rd_data = stored_ref_q[1];
      PN_STORED_REF3: par_rd_data = stored_ref_q[2];
      PN_STORED_REF4: par_rd_data = stored_ref_q[3];
      default: par_rd_data = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_gate_forces_zero: assert property (!ref_gate_on_q |=> pre_ramp_ref_q == 0)
    else $error("pre-ramp reference nonzero while gate off");
  a_permit_clears_gate: assert property (!permit_s_q |=> !ref_gate_on_q)
    else $error("gate on without run permit");
  a_gate_set_refused: assert property (par_wr_refused
    |=> (!ref_gate_on_q ##1 !ref_gate_on_q) or permit_s_q)
    else $error("refused gate write took effect");
  a_prog_gate_drive: assert property (permit_s_q && seq_logic_disable
    |=> ref_gate_on_q == $past(prog_ref_gate_on))
    else $error("programmable input did not drive gate");
  a_gate_write_lands: assert property (permit_s_q && !seq_logic_disable && gate_wr
    |=> ref_gate_on_q == $past(par_wr_data[0]))
    else $error("gate write with permit did not land");
  a_gate_passes: assert property (ref_gate_on_q
    |=> pre_ramp_ref_q == $past(limited))
    else $error("gated reference not passed on");
  a_fwd_max_limit: assert property (pre_ramp_ref_q > 0 |-> pre_ramp_ref_q <= $past(fwd_max_q))
    else $error("forward maximum exceeded");
  a_rev_max_limit: assert property (pre_ramp_ref_q < 0 |-> pre_ramp_ref_q >= $past(rev_max_q))
    else $error("reverse maximum exceeded");
  a_unipolar_no_neg: assert property (!signed_sel_q && !pol_inv_q |=> pre_ramp_ref_q >= 0)
    else $error("negative demand in unipolar mode");
  a_fwd_min_raise: assert property (!signed_sel_q && ref_gate_on_q && limited > 0
    && fwd_min_q <= fwd_max_q |=> pre_ramp_ref_q >= $past(fwd_min_q))
    else $error("forward minimum not enforced");
  a_rev_min_raise: assert property (!signed_sel_q && ref_gate_on_q && limited < 0
    && rev_min_q >= rev_max_q |=> pre_ramp_ref_q <= $past(rev_min_q))
    else $error("reverse minimum not enforced");
  // bipolar mode must pass small demands untouched, or zero would chatter
  a_min_ignored_bip: assert property (signed_sel_q && ref_gate_on_q && inverted > 0
    && inverted <= fwd_max_q |=> pre_ramp_ref_q == $past(inverted))
    else $error("minimum applied in bipolar mode");
  a_zero_stays_zero: assert property (ref_gate_on_q && inverted == 0
    |=> pre_ramp_ref_q == 0)
    else $error("zero demand moved by limits");
  a_unipolar_zero: assert property (!signed_sel_q && !pol_inv_q && ref_gate_on_q
    && post_off < 0 |=> pre_ramp_ref_q == 0)
    else $error("negative unipolar demand not zeroed");
  a_reverse_sign: assert property (signed_sel_q && pol_inv_q && ref_gate_on_q
    && post_off > 0 |=> pre_ramp_ref_q <= 0)
    else $error("reversal did not invert polarity");
  a_post_offset_sum: assert property (17'(src_ref) + 17'(offset_q) <= 17'(FULL_POS)
    && 17'(src_ref) + 17'(offset_q) >= 17'(FULL_NEG)
    |=> post_offset_q == $past(src_ref) + $past(offset_q))
    else $error("post-offset is not source plus offset");
  a_offset_saturate: assert property (17'(src_ref) + 17'(offset_q) > 17'(FULL_POS)
    |=> post_offset_q == FULL_POS)
    else $error("offset sum not saturated");
  a_source_select: assert property (!jog_sel_q && !src_hi_q && src_lo_q
    |=> pre_offset_q == $past(stored_ref_q[1]))
    else $error("wrong stored reference selected");
  a_source_one: assert property (!jog_sel_q && !src_hi_q && !src_lo_q
    |=> pre_offset_q == $past(stored_ref_q[0]))
    else $error("reference one not selected");
  a_source_four: assert property (!jog_sel_q && src_hi_q && src_lo_q
    |=> pre_offset_q == $past(stored_ref_q[3]))
    else $error("reference four not selected");
  a_jog_override: assert property (jog_sel_q |=> pre_offset_q == $past(jog_ref_q))
    else $error("inch reference not substituted");
  a_stored_write: assert property (par_wr_en && par_wr_num == PN_STORED_REF2
    |=> stored_ref_q[1] == $past(wr_full))
    else $error("stored reference write lost");
  a_route_one: assert property (route_ext_to_ref_one
    |=> stored_ref_q[0] == $past(route_val[0]))
    else $error("external input not routed to reference one");
  a_stored_range: assert property (stored_ref_q[0] <= FULL_POS && stored_ref_q[0] >= FULL_NEG
    && stored_ref_q[3] <= FULL_POS && stored_ref_q[3] >= FULL_NEG)
    else $error("stored reference out of range");
  a_rev_max_range: assert property (rev_max_q <= ZERO_REF && rev_max_q >= FULL_NEG
    && (FOUR_QUADRANT || rev_max_q == ZERO_REF))
    else $error("reverse maximum out of range");
  a_interlock_block: assert property (start_ilk_q && pre_offset_q >= ILK_WINDOW_POS
    |=> !start_permit_q)
    else $error("start permitted outside zero window");
  a_interlock_pass: assert property (start_ilk_q && pre_offset_q > ILK_WINDOW_NEG
    && pre_offset_q < ILK_WINDOW_POS |=> start_permit_q)
    else $error("start blocked inside zero window");
  // with the interlock off nothing may hold the drive back
  a_interlock_off: assert property (!start_ilk_q
    |=> start_permit_q)
    else $error("start blocked with interlock off");

endmodule

// File: verification/srs_ramp_model.sv
/*
  Model of the ramp stage that takes the pre-ramp reference.
  Assumes the selector's clock and synchronous active-low reset.
*/
`timescale 1ns/10ps
module srs_ramp_model
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ramp_enable,
  input wire logic signed [15:0] pre_ramp_ref,
  output logic signed [15:0] post_ramp_ref
);
  logic signed [15:0] ramp_q;

  // ----------------------------------------------------------------------
  // ramp: one count per cycle toward the demand
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ramp_q <= 16'sh0000;
    else if (!ramp_enable)
      ramp_q <= pre_ramp_ref;
    else if (ramp_q < pre_ramp_ref)
      ramp_q <= ramp_q + 16'sh0001;
    else if (ramp_q > pre_ramp_ref)
      ramp_q <= ramp_q - 16'sh0001;
  end

  // bypass is combinational so a disabled ramp adds no delay
  assign post_ramp_ref = ramp_enable ? ramp_q : pre_ramp_ref;
endmodule

// File: verification/tb_speed_reference_selector.sv
/*
  Self-checking testbench of the speed reference selector with a ramp model.
  Assumes a 50 MHz clock and the parameter port latencies of the hand-over.
*/
`timescale 1ns/10ps
module tb_speed_reference_selector;
  import srs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic par_wr_en = 1'b0;
  logic [4:0] par_wr_num = 5'h00;
  logic [15:0] par_wr_data = 16'h0000;
  logic [4:0] par_rd_num = 5'h00;
  logic [15:0] par_rd_data;
  logic par_wr_refused;
  logic run_permit_input = 1'b0;
  logic [15:0] ext_pin = 16'h0000;
  logic [15:0] gp3 = 16'h0000;
  logic [15:0] gp4 = 16'h0000;
  logic rt1 = 1'b0;
  logic rt3 = 1'b0;
  logic rt4 = 1'b0;
  logic seq_dis = 1'b0;
  logic prog_on = 1'b0;
  logic signed [15:0] pre_ramp_ref_q;
  logic signed [15:0] post_ramp;
  logic start_permit_q;
  logic ref_gate_on_q;
  logic [15:0] lfsr_q = 16'h004A;
  logic [15:0] v;
  logic last_refused;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int src[4];
  int off, jog, fmax, fmin, rmax, rmin, lim, sel, e_pre, e_post, e_fin;
  bit bip, inv, jsel;
  int ilk_v[5] = '{7, 8, -7, -8, 0};

  srs_speed_ref dut_u (.core_clk(core_clk), .rst_n(rst_n), .par_wr_en(par_wr_en),
    .par_wr_num(par_wr_num), .par_wr_data(par_wr_data), .par_rd_num(par_rd_num),
    .par_rd_data(par_rd_data), .par_wr_refused(par_wr_refused),
    .run_permit_input(run_permit_input), .external_speed_input_pin(ext_pin),
    .general_analog_input_three(gp3), .general_analog_input_four(gp4),
    .route_ext_to_ref_one(rt1), .route_gp_to_ref_three(rt3), .route_gp_to_ref_four(rt4),
    .seq_logic_disable(seq_dis), .prog_ref_gate_on(prog_on),
    .pre_ramp_ref_q(pre_ramp_ref_q), .start_permit_q(start_permit_q),
    .ref_gate_on_q(ref_gate_on_q));

  srs_ramp_model ramp_u (.core_clk(core_clk), .rst_n(rst_n), .ramp_enable(1'b0),
    .pre_ramp_ref(pre_ramp_ref_q), .post_ramp_ref(post_ramp));

  // ----------------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------------
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic int rng(input int lo, input int hi);
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lo + int'(lfsr_q) % (hi - lo + 1);
  endfunction

  // refused strobe is combinational, so it is caught mid-cycle
  task automatic wr(input logic [4:0] n, input int d);
    @(posedge core_clk);
    par_wr_en <= 1'b1;
    par_wr_num <= n;
    par_wr_data <= 16'(d);
    @(negedge core_clk);
    last_refused = par_wr_refused;
    @(posedge core_clk);
    par_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] n, output logic [15:0] d);
    @(posedge core_clk);
    par_rd_num <= n;
    @(negedge core_clk);
    d = par_rd_data;
  endtask

  task automatic settle();
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  function automatic logic [15:0] rst_val(input int n);
    case (n)
      4: return RST_OFFSET;
      5: return RST_JOG_REF;
      6: return RST_FWD_MAX;
      7: return RST_FWD_MIN;
      8: return RST_REV_MIN;
      9: return RST_REV_MAX_4Q;
      10: return 16'h0001;
      18: return RST_STORED_REF2;
      default: return 16'h0000;
    endcase
  endfunction

  // saturating limits; minimums only count in unipolar mode
  function automatic int lim_ref(input int x, input bit b, input bit iv);
    if (!b && x < 0) x = 0;
    if (iv) x = -x;
    if (x > 0)
    begin
      if (!b && x < fmin) x = fmin;
      if (x > fmax) x = fmax;
    end
    else if (x < 0)
    begin
      if (!b && x > rmin) x = rmin;
      if (x < rmax) x = rmax;
    end
    return x;
  endfunction

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int n = 4; n <= 20; n++)
    begin
      rd(5'(n), v);
      chk("reset value", v, rst_val(n));
    end
    rd(5'h15, v);
    chk("unmapped read", v, 16'h0000);
    wr(PN_PRE_RAMP_MON, 16'h0123);
    rd(PN_PRE_RAMP_MON, v);
    chk("monitor write", v, 16'h0000);
    wr(PN_REF_GATE_ON, 1);
    chk("refused strobe", {15'h0000, last_refused}, 16'h0001);
    settle();
    chk("gate held off", {15'h0000, ref_gate_on_q}, 16'h0000);
    @(posedge core_clk);
    run_permit_input <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(PN_REF_GATE_ON, 1);
    settle();
    chk("gate on", {15'h0000, ref_gate_on_q}, 16'h0001);
    for (int i = 0; i < 40; i++)
    begin
      foreach (src[k]) src[k] = rng(-1000, 1000);
      off = rng(-1000, 1000);
      bip = 1'(rng(0, 1));
      inv = 1'(rng(0, 1));
      jsel = i > 3 && rng(0, 3) == 0;
      sel = i % 4;
      fmax = rng(0, 1000);
      fmin = rng(0, 1000);
      rmax = rng(-1000, 0);
      rmin = rng(-1000, 0);
      if (i == 0)
      begin
        foreach (src[k]) src[k] = 0;
        off = 0;
        bip = 1'b1;
      end
      lim = fmax < -rmax ? fmax : -rmax;
      jog = lim > 1 ? rng(1 - lim, lim - 1) : 0;
      foreach (src[k]) wr(PN_STORED_REF1 + 5'(k), src[k]);
      wr(PN_REF_OFFSET, off);
      wr(PN_JOG_REF, jog);
      wr(PN_FWD_MAX, fmax);
      wr(PN_FWD_MIN, fmin);
      wr(PN_REV_MIN, rmin);
      wr(PN_REV_MAX, rmax);
      wr(PN_SIGNED_SEL, int'(bip));
      wr(PN_POL_INVERT, int'(inv));
      wr(PN_JOG_SEL, int'(jsel));
      wr(PN_SRC_SEL_LOW, sel % 2);
      wr(PN_SRC_SEL_HIGH, sel / 2);
      settle();
      e_pre = jsel ? jog : src[sel];
      e_post = e_pre + off > 1000 ? 1000 : (e_pre + off < -1000 ? -1000 : e_pre + off);
      e_fin = lim_ref(e_post, bip, inv);
      rd(PN_PRE_OFFSET_MON, v);
      chk("pre-offset", v, 16'(e_pre));
      rd(PN_POST_OFFSET_MON, v);
      chk("post-offset", v, 16'(e_post));
      rd(PN_PRE_RAMP_MON, v);
      chk("pre-ramp monitor", v, 16'(e_fin));
      chk("pre-ramp", pre_ramp_ref_q, 16'(e_fin));
      chk("post-ramp", post_ramp, 16'(e_fin));
    end
    wr(PN_JOG_SEL, 0);
    wr(PN_SRC_SEL_LOW, 0);
    wr(PN_SRC_SEL_HIGH, 0);
    wr(PN_START_ILK, 1);
    foreach (ilk_v[k])
    begin
      wr(PN_STORED_REF1, ilk_v[k]);
      settle();
      chk("start permit", {15'h0000, start_permit_q}, 16'(ilk_v[k] > -8 && ilk_v[k] < 8));
    end
    @(posedge core_clk);
    ext_pin <= 16'(rng(-1000, 1000));
    gp3 <= 16'(rng(-1000, 1000));
    gp4 <= 16'(rng(-1000, 1000));
    rt1 <= 1'b1;
    rt3 <= 1'b1;
    rt4 <= 1'b1;
    wr(PN_STORED_REF1, 5);
    settle();
    rd(PN_STORED_REF1, v);
    chk("routed ref one", v, ext_pin);
    rd(PN_STORED_REF3, v);
    chk("routed ref three", v, gp3);
    rd(PN_STORED_REF4, v);
    chk("routed ref four", v, gp4);
    @(posedge core_clk);
    seq_dis <= 1'b1;
    settle();
    chk("input gate off", {15'h0000, ref_gate_on_q}, 16'h0000);
    @(posedge core_clk);
    prog_on <= 1'b1;
    settle();
    chk("input gate on", {15'h0000, ref_gate_on_q}, 16'h0001);
    @(posedge core_clk);
    run_permit_input <= 1'b0;
    settle();
    chk("permit loss gate", {15'h0000, ref_gate_on_q}, 16'h0000);
    chk("permit loss ref", pre_ramp_ref_q, 16'h0000);
    summarize();
  end
endmodule
